// ---- verilog/gdo_pkg.sv ----
package gdo_pkg;
   // Clock and the one second tick.
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_PERIOD_S = 1;
   localparam int TICK_CYCLES_DEF = CLK_HZ * TICK_PERIOD_S;
   // Holdoff choices, printed units first, then in seconds.
   localparam int HOLD_SHORT_MIN = 10;
   localparam int HOLD_LONG_H = 8;
   localparam logic [15:0] HOLD_SHORT_S = 16'(HOLD_SHORT_MIN * 60);
   localparam logic [15:0] HOLD_LONG_S = 16'(HOLD_LONG_H * 3600);
   // Last count of each averaging period; the period in seconds is one more.
   localparam logic [12:0] AVG_QUARTZ_MAX = 13'h01FF;
   localparam logic [12:0] AVG_ATOM_UNST_MAX = 13'h07FF;
   localparam logic [12:0] AVG_ATOM_STAB_MAX = 13'h1FFF;
   // Stability index range and the step sizes that move it.
   localparam logic [3:0] IDX_MIN = 4'h4;
   localparam logic [3:0] IDX_MAX = 4'h8;
   localparam logic [15:0] STEP_SETTLED = 16'h0001;
   localparam logic [15:0] STEP_UNSETTLED = 16'h0040;
   // Register byte offsets.
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CONTROL_VAL = 8'h08;
   localparam logic [7:0] REG_PERIOD_CNT = 8'h0C;
   localparam logic [7:0] REG_OUTAGE = 8'h10;
   localparam logic [7:0] REG_TOD = 8'h14;
   localparam logic [7:0] REG_DAY = 8'h18;
   localparam logic [7:0] REG_LEAP = 8'h1C;
   localparam logic [7:0] REG_LEAP_CTL = 8'h20;
   localparam logic [7:0] REG_PWR_TIME = 8'h24;
   localparam logic [7:0] REG_FIX_TIME = 8'h28;
   localparam logic [7:0] REG_WEEK = 8'h2C;
   localparam logic [7:0] REG_HIST_BASE = 8'h30;
   localparam logic [7:0] REG_DAILY_BASE = 8'h50;
   localparam int HIST_DEPTH = 8;
   localparam int DAILY_DEPTH = 12;
   // Control register fields and reset values.
   localparam int CTRL_HOLD_LONG = 0;
   localparam int CTRL_ATOMIC = 1;
   localparam int CTRL_LEAP_NC = 2;
   localparam int CTRL_DYN_LSB = 3;
   localparam int CTRL_GAIN_LSB = 8;
   localparam logic [3:0] GAIN_RST = 4'h4;
   localparam logic [15:0] CONTROL_VAL_RST = 16'h8000;
   // Time of day fields.
   localparam logic [4:0] LAST_HOUR = 5'h17;
   localparam logic [5:0] LAST_MIN = 6'h3B;
   localparam logic [5:0] LEAP_SEC = 6'h3C;
   localparam int DIV_STEPS = 40;
   // AXI responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Receiver dynamics modes.
   typedef enum logic [1:0] {DYN_AIR, DYN_SEA, DYN_LAND, DYN_STATIC} dyn_t;
endpackage

// ---- verilog/gdo_control.sv ----
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module gdo_control
   import gdo_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // GPS receiver
   input wire logic gps_pps,
   input wire logic gps_fix,
   input wire logic gps_fix_3d,
   input wire logic [15:0] gps_height,
   input wire logic [15:0] gps_week,
   output logic [1:0] rx_dyn_mode,
   output logic fixed_height_nav,
   output logic [15:0] nav_height,
   // Oscillator and timing outputs
   output logic [15:0] osc_control,
   output logic tick_1hz,
   output logic [5:0] tod_sec
);
   typedef struct packed {
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic hold_long;
      logic atomic;
      logic leap_nc;
      logic [1:0] dyn;
      logic [3:0] gain;
      logic [31:0] div;
      logic [31:0] phase;
      logic signed [31:0] acc;
      logic [12:0] cnt;
      logic [3:0] idx;
      logic [15:0] ctl;
      logic [15:0] step;
      logic [HIST_DEPTH-1:0][15:0] hist;
      logic [DAILY_DEPTH-1:0][15:0] daily;
      logic fix_d;
      logic holdover;
      logic realign_pend;
      logic [15:0] outage;
      logic [4:0] hour;
      logic [5:0] min;
      logic [5:0] sec;
      logic [15:0] day;
      logic leap_rep;
      logic leap_sched;
      logic [15:0] leap_date;
      logic [7:0] leap_new;
      logic [7:0] leap_old;
      logic pwr_taken;
      logic [20:0] pwr_stamp;
      logic [20:0] fix_stamp;
      logic [15:0] height;
      logic [39:0] dsum;
      logic [16:0] dn;
      logic dbusy;
      logic [5:0] di;
      logic [39:0] dq;
      logic [17:0] drem;
      logic [16:0] ddiv;
   } st_t;

   st_t s_r, s_nxt;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = nw[8*b +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [20:0] stamp(input st_t s);
      return {s.hour, 2'h0, s.min, 2'h0, s.sec};
   endfunction

   logic tick;
   logic loop_on;
   logic [12:0] cnt_max;
   logic signed [31:0] err;
   logic [31:0] phs;
   logic signed [31:0] step_s;
   logic [15:0] step_v;
   logic [15:0] step_mag;
   logic [15:0] holdoff_s;
   logic [31:0] rd;
   logic rd_ok;
   logic [31:0] wr;
   logic [7:0] hidx;
   logic [7:0] didx;
   logic [17:0] rtry;

   always_comb begin
      // A realign makes the tick coincide with the GPS pulse.
      tick = (s_r.div == 32'(TICK_CYCLES - 1)) ||
             (s_r.realign_pend && gps_pps);
      loop_on = gps_fix && !s_r.realign_pend;
      holdoff_s = s_r.hold_long ? HOLD_LONG_S : HOLD_SHORT_S;
      if (!s_r.atomic) begin
         cnt_max = AVG_QUARTZ_MAX;
      end else if (s_r.idx == IDX_MAX) begin
         cnt_max = AVG_ATOM_STAB_MAX;
      end else begin
         cnt_max = AVG_ATOM_UNST_MAX;
      end
      // Signed distance from the last internal tick to the GPS pulse; a
      // pulse in the tick's own cycle is aligned and counts as zero.
      phs = tick ? 32'h0 : s_r.phase + 32'h1;
      if (phs < 32'(TICK_CYCLES / 2)) begin
         err = $signed(phs);
      end else begin
         err = $signed(phs - 32'(TICK_CYCLES));
      end
      step_s = -(s_r.acc >>> s_r.gain);
      step_v = step_s[15:0];
      step_mag = step_v[15] ? 16'(-step_v) : step_v;
      hidx = 8'((s_r.aw_addr - REG_HIST_BASE) >> 2);
      didx = 8'((s_r.aw_addr - REG_DAILY_BASE) >> 2);
      rtry = {s_r.drem[16:0], s_r.dq[39]};
   end

   always_comb begin
      logic [7:0] ra;
      ra = s_axi_araddr;
      rd = 32'h0;
      rd_ok = 1'b1;
      if (ra >= REG_HIST_BASE && ra < REG_DAILY_BASE) begin
         rd = {16'h0, s_r.hist[3'((ra - REG_HIST_BASE) >> 2)]};
      end else if (ra >= REG_DAILY_BASE &&
                   ra < 8'(REG_DAILY_BASE + 4 * DAILY_DEPTH)) begin
         rd = {16'h0, s_r.daily[4'((ra - REG_DAILY_BASE) >> 2)]};
      end else begin
         case (ra)
            REG_CTRL: rd = {20'h0, s_r.gain, 3'h0, s_r.dyn, s_r.leap_nc,
                            s_r.atomic, s_r.hold_long};
            REG_STATUS: rd = {24'h0, s_r.idx, s_r.leap_sched,
                              s_r.realign_pend, s_r.holdover, gps_fix};
            REG_CONTROL_VAL: rd = {s_r.step, s_r.ctl};
            REG_PERIOD_CNT: rd = {19'h0, s_r.cnt};
            REG_OUTAGE: rd = {16'h0, s_r.outage};
            REG_TOD: rd = {11'h0, stamp(s_r)};
            REG_DAY: rd = {16'h0, s_r.day};
            // Offsets are hidden while nothing is scheduled.
            REG_LEAP: rd = s_r.leap_sched ? {s_r.leap_old, s_r.leap_new,
                                             s_r.leap_date} : 32'h0;
            REG_LEAP_CTL: rd = {31'h0, s_r.leap_sched};
            REG_PWR_TIME: rd = {11'h0, s_r.pwr_stamp};
            REG_FIX_TIME: rd = {11'h0, s_r.fix_stamp};
            REG_WEEK: rd = {16'h0, gps_week};
            default: rd_ok = 1'b0;
         endcase
      end
   end

   always_comb begin
      s_nxt = s_r;
      wr = 32'h0;
      // Bus slave: address and data are taken independently.
      if (s_axi_awvalid && s_axi_awready) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_nxt.w_have = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = rd;
         s_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end

      // Divider and phase measurement.
      s_nxt.div = tick ? 32'h0 : s_r.div + 32'h1;
      s_nxt.phase = tick ? 32'h0 : s_r.phase + 32'h1;
      if (gps_pps && loop_on) begin
         s_nxt.acc = s_r.acc + err;
      end

      // Outage timing and recovery choice.
      s_nxt.fix_d = gps_fix;
      if (!gps_fix && s_r.fix_d) begin
         s_nxt.holdover = 1'b1;
         s_nxt.outage = 16'h0;
      end else if (!gps_fix && tick && s_r.outage != 16'hFFFF) begin
         s_nxt.outage = s_r.outage + 16'h1;
      end
      if (gps_fix && !s_r.fix_d) begin
         s_nxt.holdover = 1'b0;
         s_nxt.fix_stamp = stamp(s_r);
         if (s_r.outage > holdoff_s && s_r.pwr_taken) begin
            s_nxt.realign_pend = 1'b1;
         end
         // Otherwise acc is kept and the loop resumes as it was.
      end
      if (s_r.realign_pend && gps_pps) begin
         s_nxt.realign_pend = 1'b0;
         s_nxt.acc = 32'sh0;
         s_nxt.cnt = 13'h0;
      end

      // Averaging period and steering.
      if (tick && loop_on) begin
         if (s_r.cnt >= cnt_max) begin
            s_nxt.cnt = 13'h0;
            s_nxt.acc = 32'sh0;
            s_nxt.ctl = s_r.ctl + step_v;
            s_nxt.step = step_v;
            s_nxt.hist = {s_r.hist[HIST_DEPTH-2:0],
                          16'(s_r.ctl + step_v)};
            if (step_mag > STEP_UNSETTLED) begin
               s_nxt.idx = IDX_MIN;
            end else if (step_mag <= STEP_SETTLED && s_r.idx < IDX_MAX) begin
               s_nxt.idx = s_r.idx + 4'h1;
            end
         end else begin
            s_nxt.cnt = s_r.cnt + 13'h1;
         end
      end

      // Time of day with leap second handling.
      if (tick) begin
         if (!s_r.pwr_taken) begin
            s_nxt.pwr_taken = 1'b1;
            s_nxt.pwr_stamp = stamp(s_r);
         end
         s_nxt.dsum = s_r.dsum + {24'h0, s_r.ctl};
         s_nxt.dn = s_r.dn + 17'h1;
         if (s_r.leap_sched && s_r.day == s_r.leap_date &&
             s_r.hour == LAST_HOUR && s_r.min == LAST_MIN &&
             s_r.sec == LAST_MIN && !s_r.leap_rep) begin
            s_nxt.leap_rep = 1'b1;
            if (!s_r.leap_nc) begin
               s_nxt.sec = LEAP_SEC;
            end
            // Non-compliant mode leaves the count at 59 once more.
         end else if (s_r.sec >= LAST_MIN) begin
            s_nxt.sec = 6'h0;
            if (s_r.min == LAST_MIN) begin
               s_nxt.min = 6'h0;
               if (s_r.hour == LAST_HOUR) begin
                  s_nxt.hour = 5'h0;
                  s_nxt.day = s_r.day + 16'h1;
                  // Midnight closes the daily average.
                  s_nxt.dsum = {24'h0, s_r.ctl};
                  s_nxt.dn = 17'h1;
                  s_nxt.dbusy = 1'b1;
                  s_nxt.di = 6'h0;
                  s_nxt.dq = s_r.dsum + {24'h0, s_r.ctl};
                  s_nxt.ddiv = s_r.dn + 17'h1;
                  s_nxt.drem = 18'h0;
                  if (s_r.leap_rep) begin
                     s_nxt.leap_rep = 1'b0;
                     s_nxt.leap_sched = 1'b0;
                     s_nxt.leap_old = s_r.leap_new;
                  end
               end else begin
                  s_nxt.hour = s_r.hour + 5'h1;
               end
            end else begin
               s_nxt.min = s_r.min + 6'h1;
            end
         end else begin
            s_nxt.sec = s_r.sec + 6'h1;
         end
      end

      // Serial divider for the daily mean, one quotient bit per cycle.
      if (s_r.dbusy) begin
         s_nxt.di = s_r.di + 6'h1;
         if (rtry >= {1'b0, s_r.ddiv}) begin
            s_nxt.drem = rtry - {1'b0, s_r.ddiv};
            s_nxt.dq = {s_r.dq[38:0], 1'b1};
         end else begin
            s_nxt.drem = rtry;
            s_nxt.dq = {s_r.dq[38:0], 1'b0};
         end
         if (s_r.di == 6'(DIV_STEPS - 1)) begin
            s_nxt.dbusy = 1'b0;
            s_nxt.daily = {s_r.daily[DAILY_DEPTH-2:0],
                           s_nxt.dq[15:0]};
         end
      end

      // Height is captured only while a 3D fix is computing it.
      if (s_r.dyn != DYN_SEA && gps_fix_3d) begin
         s_nxt.height = gps_height;
      end

      // Register writes land last so software overrides hardware.
      if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = RESP_OKAY;
         case (s_r.aw_addr)
            REG_CTRL: begin
               wr = merge({20'h0, s_r.gain, 3'h0, s_r.dyn, s_r.leap_nc,
                           s_r.atomic, s_r.hold_long},
                          s_r.w_data, s_r.w_strb);
               s_nxt.hold_long = wr[CTRL_HOLD_LONG];
               s_nxt.atomic = wr[CTRL_ATOMIC];
               s_nxt.leap_nc = wr[CTRL_LEAP_NC];
               s_nxt.dyn = wr[CTRL_DYN_LSB +: 2];
               s_nxt.gain = wr[CTRL_GAIN_LSB +: 4];
            end
            REG_CONTROL_VAL: begin
               wr = merge({16'h0, s_r.ctl}, s_r.w_data, s_r.w_strb);
               s_nxt.ctl = wr[15:0];
            end
            REG_TOD: begin
               wr = merge({11'h0, stamp(s_r)}, s_r.w_data, s_r.w_strb);
               s_nxt.sec = wr[5:0];
               s_nxt.min = wr[13:8];
               s_nxt.hour = wr[20:16];
            end
            REG_DAY: begin
               wr = merge({16'h0, s_r.day}, s_r.w_data, s_r.w_strb);
               s_nxt.day = wr[15:0];
            end
            REG_LEAP: begin
               wr = merge({s_r.leap_old, s_r.leap_new, s_r.leap_date},
                          s_r.w_data, s_r.w_strb);
               s_nxt.leap_date = wr[15:0];
               s_nxt.leap_new = wr[23:16];
               s_nxt.leap_old = wr[31:24];
            end
            REG_LEAP_CTL: begin
               if (s_r.w_strb[0]) begin
                  s_nxt.leap_sched = s_r.w_data[0];
               end
            end
            default: begin
               if (hidx >= 8'(HIST_DEPTH) && didx >= 8'(DAILY_DEPTH) &&
                   s_r.aw_addr != REG_STATUS &&
                   s_r.aw_addr != REG_PERIOD_CNT &&
                   s_r.aw_addr != REG_OUTAGE &&
                   s_r.aw_addr != REG_PWR_TIME &&
                   s_r.aw_addr != REG_FIX_TIME &&
                   s_r.aw_addr != REG_WEEK) begin
                  s_nxt.bresp = RESP_SLVERR;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.gain <= GAIN_RST;
         s_r.dyn <= DYN_LAND;
         s_r.idx <= IDX_MIN;
         s_r.ctl <= CONTROL_VAL_RST;
         s_r.fix_d <= 1'b0;
         s_r.holdover <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready = !s_r.aw_have && !s_r.bvalid;
   assign s_axi_wready = !s_r.w_have && !s_r.bvalid;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = !s_r.rvalid;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign osc_control = s_r.ctl;
   assign tick_1hz = tick;
   assign tod_sec = s_r.sec;
   assign rx_dyn_mode = s_r.dyn;
   assign fixed_height_nav = (s_r.dyn == DYN_SEA);
   assign nav_height = fixed_height_nav ? s_r.height : gps_height;
endmodule
`default_nettype wire

// ---- verif/gdo_control_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
module gdo_control_properties #(
   parameter int TICK_CYCLES = 20
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Receiver and oscillator
   input wire logic gps_pps,
   input wire logic gps_fix,
   input wire logic [15:0] gps_height,
   input wire logic [1:0] rx_dyn_mode,
   input wire logic fixed_height_nav,
   input wire logic [15:0] nav_height,
   input wire logic [15:0] osc_control,
   input wire logic tick_1hz,
   input wire logic [5:0] tod_sec
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // The first tick after reset has no known origin, so spacing is only
   // judged once one tick has been seen.
   int gap_r;
   logic seen_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gap_r <= 0;
         seen_r <= 1'h0;
      end else begin
         gap_r <= tick_1hz ? 0 : gap_r + 1;
         seen_r <= seen_r | tick_1hz;
      end
   end
   sequence wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   chk_write_answer: assert property (wr_both |=> ##1 s_axi_bvalid)
      else $error("write response missing");
   chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data missing");
   chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   chk_hold_freeze: assert property (
      !gps_fix [*4] |-> $stable(osc_control))
      else $error("control value moved in holdover");
   chk_tick_gap: assert property (
      tick_1hz && !gps_pps && seen_r |-> gap_r == TICK_CYCLES - 1)
      else $error("tick off schedule");
   chk_dyn_reset: assert property (
      $rose(resetn) |-> rx_dyn_mode == 2'h2)
      else $error("dynamics mode not land after reset");
   chk_sea_flag: assert property (
      fixed_height_nav == (rx_dyn_mode == 2'h1))
      else $error("fixed height flag wrong");
   chk_nav_pass: assert property (
      !fixed_height_nav |-> nav_height == gps_height)
      else $error("height not passed through");
   chk_sec_range: assert property (tod_sec <= 6'h3C)
      else $error("seconds out of range");
   chk_leap_wrap: assert property (
      $past(tod_sec) == 6'h3C && tod_sec != 6'h3C |-> tod_sec == 6'h00)
      else $error("second 60 not followed by 0");
endmodule
bind gdo_control gdo_control_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
   .clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .gps_pps, .gps_fix,
   .gps_height, .rx_dyn_mode, .fixed_height_nav, .nav_height,
   .osc_control, .tick_1hz, .tod_sec);
`default_nettype wire

// ---- verif/gps_rx_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module gps_rx_model #(
   parameter int PERIOD = 20,
   parameter int PHASE = 7
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Scenario controls
   input wire logic fix_en,
   input wire logic three_d,
   input wire logic [15:0] week_in,
   // Receiver outputs
   output logic gps_pps,
   output logic gps_fix,
   output logic gps_fix_3d,
   output logic [15:0] gps_height,
   output logic [15:0] gps_week
);
   int cnt_r;
   // The pulse runs on through a fix loss, so the block must ignore it.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_r <= 0;
         gps_pps <= 1'h0;
         gps_height <= 16'h0100;
      end else begin
         cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
         gps_pps <= (cnt_r == PHASE);
         // Height drifts each second so that a stale latch shows.
         if (cnt_r == PHASE) gps_height <= gps_height + 16'h0001;
      end
   end
   assign gps_fix = fix_en;
   assign gps_fix_3d = fix_en && three_d;
   assign gps_week = week_in;
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import gdo_pkg::*;
   localparam int TC = 20;
   logic clk = 1'h0, resetn = 1'h0, fix_en = 1'h1, three_d = 1'h1;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, gps_pps, gps_fix, gps_fix_3d, fixed_height_nav;
   logic tick_1hz;
   logic [1:0] s_axi_bresp, s_axi_rresp, rx_dyn_mode, r;
   logic [15:0] gps_height, gps_week, nav_height, osc_control, h, v;
   logic [15:0] week = 16'h0;
   logic [5:0] tod_sec;
   int num_errors = 0, comparisons = 0, cyc = 0;
   always #5 clk = ~clk;
   gdo_control #(.TICK_CYCLES(TC)) dut (
      .clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .gps_pps, .gps_fix, .gps_fix_3d,
      .gps_height, .gps_week, .rx_dyn_mode, .fixed_height_nav,
      .nav_height, .osc_control, .tick_1hz, .tod_sec);
   gps_rx_model #(.PERIOD(TC), .PHASE(7)) u_gps (
      .clk, .resetn, .fix_en, .three_d, .week_in(week), .gps_pps,
      .gps_fix, .gps_fix_3d, .gps_height, .gps_week);
   task automatic print_verdict();
      if (num_errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s,
                      input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] val);
      logic aok, wok, bok;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= val;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      // Ready is read mid-cycle, where it still shows what the edge takes.
      do begin
         @(negedge clk);
         aok = s_axi_awready;
         wok = s_axi_wready;
         bok = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk);
         if (aok) s_axi_awvalid <= 1'h0;
         if (wok) s_axi_wvalid <= 1'h0;
      end while (!bok);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      logic aok, rok;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(negedge clk);
         aok = s_axi_arready;
         rok = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
         if (aok) s_axi_arvalid <= 1'h0;
      end while (!rok);
      s_axi_rready <= 1'h0;
   endtask
   task automatic rc(input string n, input logic [7:0] a,
                     input logic [31:0] m, input logic [31:0] e);
      rd(a);
      chk(n, d & m, e);
   endtask
   function automatic logic [5:0] exp_sec(input int i, input logic nc);
      if (i < 4) return 6'h38 + 6'(i);
      if (i == 4) return nc ? 6'h3B : LEAP_SEC;
      return 6'h00;
   endfunction
   task automatic leap(input logic nc);
      logic [31:0] lv;
      lv = $urandom;
      wr(REG_LEAP_CTL, 32'h0);
      wr(REG_LEAP, lv);
      rc("leap", REG_LEAP, 32'hFFFFFFFF, 32'h0);
      wr(REG_LEAP_CTL, 32'h1);
      rc("leap", REG_LEAP, 32'hFFFFFFFF, lv);
      wr(REG_CTRL, 32'h410 | {29'h0, nc, 2'h0});
      wr(REG_DAY, {16'h0, lv[15:0]});
      @(posedge clk iff tick_1hz);
      wr(REG_TOD, 32'h00173B37);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk iff tick_1hz);
         #1;
         chk("sec", {26'h0, tod_sec}, {26'h0, exp_sec(i, nc)});
      end
      rc("leap", REG_LEAP, 32'hFFFFFFFF, 32'h0);
   endtask
   // Fix is dropped and restored on receiver pulses, so the outage holds
   // exactly one tick per pulse while the two are still out of phase.
   task automatic outage(input int secs, input logic lng, input logic re);
      wr(REG_CTRL, 32'h410 | {31'h0, lng});
      @(posedge clk iff gps_pps);
      fix_en <= 1'h0;
      rc("holdover", REG_STATUS, 32'h2, 32'h2);
      repeat (secs) @(posedge clk iff gps_pps);
      fix_en <= 1'h1;
      rc("realign", REG_STATUS, 32'h4, {29'h0, re, 2'h0});
      rc("outage", REG_OUTAGE, 32'hFFFF, 32'(secs));
      if (re) begin
         // The realigned tick stands only in the pulse's own cycle.
         @(negedge clk iff gps_pps);
         chk("tick", {31'h0, tick_1hz}, 32'h1);
      end
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 80000) begin
         num_errors++;
         print_verdict();
      end
   end
   initial begin
      void'($urandom(32'hF5C1));
      week = 16'($urandom);
      repeat (6) @(posedge clk);
      resetn <= 1'h1;
      rc("ctrl", REG_CTRL, 32'hFFF, 32'h410);
      rc("index", REG_STATUS, 32'hF0, 32'h40);
      rc("control", REG_CONTROL_VAL, 32'hFFFFFFFF, 32'h8000);
      rc("week", REG_WEEK, 32'hFFFF, {16'h0, week});
      rd(8'hFC);
      chk("rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      chk("rdata", d, 32'h0);
      wr(8'hFC, 32'h0);
      chk("bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
      for (int i = 0; i < 4; i++) begin
         wr(REG_CTRL, 32'h400 | 32'(i << 3));
         chk("dyn", {30'h0, rx_dyn_mode}, 32'(i));
         chk("fhn", {31'h0, fixed_height_nav}, 32'(i == 1));
      end
      @(posedge clk iff gps_pps);
      three_d <= 1'h0;
      wr(REG_CTRL, 32'h408);
      h = gps_height;
      repeat (60) @(posedge clk);
      chk("nav_height", {16'h0, nav_height}, {16'h0, h});
      three_d <= 1'h1;
      leap(1'h0);
      leap(1'h1);
      outage(600, 1'h0, 1'h0);
      outage(601, 1'h1, 1'h0);
      outage(601, 1'h0, 1'h1);
      v = 16'($urandom);
      wr(REG_CONTROL_VAL, {16'h0, v});
      repeat (511) @(posedge clk iff tick_1hz);
      rc("period", REG_PERIOD_CNT, 32'h1FFF, 32'h1FF);
      @(posedge clk iff tick_1hz);
      rc("period", REG_PERIOD_CNT, 32'h1FFF, 32'h0);
      rc("history", REG_HIST_BASE, 32'hFFFF, {16'h0, v});
      rc("step", REG_CONTROL_VAL, 32'hFFFFFFFF, {16'h0, v});
      rc("index", REG_STATUS, 32'hF0, 32'h50);
      print_verdict();
   end
endmodule
`default_nettype wire
